/* dpr_block_ram.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.svh"

module dpr_block_ram
  import dpr_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`DPR_PADDR_W-1:0]   paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      a_ce,
  input  wire logic                      a_wren,
  input  wire logic                      a_clr,
  input  wire logic [`DPR_ADDR_W-1:0]    a_addr,
  input  wire logic [`DPR_BE_W-1:0]      a_be,
  input  wire logic [`DPR_DATA_W-1:0]    a_wdata,
  output logic      [`DPR_DATA_W-1:0]    a_rdata,
  input  wire logic                      b_ce,
  input  wire logic                      b_wren,
  input  wire logic                      b_clr,
  input  wire logic [`DPR_ADDR_W-1:0]    b_addr,
  input  wire logic [`DPR_BE_W-1:0]      b_be,
  input  wire logic [`DPR_DATA_W-1:0]    b_wdata,
  output logic      [`DPR_DATA_W-1:0]    b_rdata
);

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [`DPR_ROW_W-1:0] mem [`DPR_ROWS];
  dpr_state_t            s_reg;
  dpr_state_t            s_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int wbits(input logic [3:0] c);
    int w;
    w = 0;
    if (c < `DPR_W_X9)
      w = 1 << c;
    else if (c <= `DPR_W_X36)
      w = `DPR_LANE_P << (c - `DPR_W_X9);
    return w;
  endfunction

  function automatic logic is_par(input logic [3:0] c);
    return c >= `DPR_W_X9;
  endfunction

  // {valid, row, column} of word bit i at address ad
  function automatic logic [13:0] bit_pos(input logic [3:0] c, input logic [`DPR_ADDR_W-1:0] ad,
                                          input int i);
    int w;
    int idx;
    logic [13:0] r;
    r = '0;
    w = wbits(c);
    if (w != 0 && !is_par(c)) begin
      idx = int'(ad) * w + i;
      if (i < w && idx < `DPR_NP_BITS)
        r = {1'b1, 7'(idx / 32), 6'(((idx % 32) / `DPR_LANE_NP) * `DPR_LANE_P + idx % `DPR_LANE_NP)};
    end else if (w != 0) begin
      idx = int'(ad) * (w / `DPR_LANE_P) + i / `DPR_LANE_P;
      if (i < w && idx < `DPR_P_LANES)
        r = {1'b1, 7'(idx / 4), 6'((idx % 4) * `DPR_LANE_P + i % `DPR_LANE_P)};
    end
    return r;
  endfunction

  // out-of-range bits read back as zero
  function automatic logic [`DPR_DATA_W-1:0] rd_word(input logic [3:0] c,
                                                     input logic [`DPR_ADDR_W-1:0] ad);
    logic [`DPR_DATA_W-1:0] v;
    logic [13:0]            p;
    v = '0;
    for (int i = 0; i < `DPR_DATA_W; i++) begin
      p = bit_pos(c, ad, i);
      if (p[13])
        v[i] = mem[p[12:6]][p[5:0]];
    end
    return v;
  endfunction

  // byte lane gate for bit i of a write word
  function automatic logic lane_on(input logic [3:0] c, input logic msk, input logic [`DPR_BE_W-1:0] be,
                                   input int i);
    logic cap;
    cap = msk && (c == `DPR_W_X16 || c == `DPR_W_X32 || c == `DPR_W_X18 || c == `DPR_W_X36);
    if (!cap)
      return 1'b1;
    return is_par(c) ? be[i / `DPR_LANE_P] : be[i / `DPR_LANE_NP];
  endfunction

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic [3:0]              wa;
  logic [3:0]              wb;
  dpr_mode_t               mode;
  logic                    mode_bad;
  logic                    cfg_err;
  logic                    sh_err;
  logic                    run_ok;
  logic [`DPR_SHIFT_M_W-1:0] tap_m;
  logic [`DPR_SHIFT_N_W-1:0] tap_n;
  int                      sh_words;

  // an illegal shape or mode stops both ports until software fixes it
  always_comb begin
    wa       = s_reg.width[3:0];
    wb       = s_reg.width[7:4];
    mode_bad = s_reg.ctrl[`DPR_CTRL_MODE+:3] >= `DPR_MODE_NUM;
    mode     = mode_bad ? DPR_TDP : dpr_mode_t'(s_reg.ctrl[`DPR_CTRL_MODE+:3]);
    tap_m    = s_reg.shift[`DPR_SHIFT_M_W-1:0];
    tap_n    = s_reg.shift[`DPR_SHIFT_M_W+:`DPR_SHIFT_N_W];
    sh_words = int'(tap_m) * int'(tap_n);
    cfg_err  = mode_bad || wbits(wa) == 0 || wbits(wb) == 0 || is_par(wa) != is_par(wb);
    if (mode == DPR_TDP && (wa == `DPR_W_X32 || wa == `DPR_W_X36 || wb == `DPR_W_X32 || wb == `DPR_W_X36))
      cfg_err = 1'b1;
    sh_err   = mode == DPR_SHIFT && (sh_words == 0 || wbits(wa) * sh_words > `DPR_BITS);
    run_ok   = s_reg.ctrl[`DPR_CTRL_RUN] && !cfg_err && !sh_err;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic                    a_in_ce;
  logic                    a_out_ce;
  logic                    b_in_ce;
  logic                    b_out_ce;
  logic                    b_act;
  logic [`DPR_DATA_W-1:0]  a_mem;
  logic [`DPR_DATA_W-1:0]  b_mem;
  logic                    acc;
  logic                    wr_commit;
  logic                    mapped;
  logic [31:0]             rdv;

  always_comb begin
    s_next   = s_reg;
    a_in_ce  = s_reg.ctrl[`DPR_CTRL_AIN] ? b_ce : a_ce;
    a_out_ce = s_reg.ctrl[`DPR_CTRL_AOUT] ? b_ce : a_ce;
    b_in_ce  = s_reg.ctrl[`DPR_CTRL_BIN] ? a_ce : b_ce;
    b_out_ce = s_reg.ctrl[`DPR_CTRL_BOUT] ? a_ce : b_ce;
    b_act    = run_ok && (mode == DPR_TDP || mode == DPR_SDP || mode == DPR_FIFO);
    a_mem    = rd_word(wa, s_reg.pa.addr);
    b_mem    = rd_word(wb, s_reg.pb.addr);

    // port A input stage, always registered
    s_next.pa.go = 1'b0;
    if (run_ok && a_in_ce) begin
      s_next.pa.addr = mode == DPR_SHIFT ? s_reg.sptr : a_addr;
      s_next.pa.be   = mode == DPR_SHIFT ? '1 : a_be;
      s_next.pa.wd   = a_wdata;
      s_next.pa.go   = mode == DPR_SHIFT || (a_wren && mode != DPR_ROM);
      // pointer wraps after m*n words, giving that delay
      if (mode == DPR_SHIFT)
        s_next.sptr = int'(s_reg.sptr) + 1 >= sh_words ? '0 : s_reg.sptr + 1'b1;
    end
    // port B input stage
    s_next.pb.go = 1'b0;
    if (b_act && b_in_ce) begin
      s_next.pb.addr = b_addr;
      s_next.pb.be   = b_be;
      s_next.pb.wd   = b_wdata;
      s_next.pb.go   = b_wren && mode == DPR_TDP;
    end

    // read path: array latch, then optional output register
    s_next.pa.rq = a_mem;
    s_next.pb.rq = b_mem;
    if (s_reg.ctrl[`DPR_CTRL_ABYP])
      s_next.pa.rd = a_mem;
    else if (a_out_ce)
      s_next.pa.rd = s_reg.pa.rq;
    if (s_reg.ctrl[`DPR_CTRL_BBYP])
      s_next.pb.rd = b_mem;
    else if (b_out_ce)
      s_next.pb.rd = s_reg.pb.rq;

    // clear wins over a capture in the same cycle
    if (a_clr)
      s_next.pa = '0;
    if (b_clr)
      s_next.pb = '0;

    // register bus slave: one wait state, then pready
    acc       = psel && penable && !s_reg.pready;
    wr_commit = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;
    mapped    = 1'b1;
    rdv       = '0;
    unique case (paddr)
      `DPR_OFF_CTRL:   rdv = 32'(s_reg.ctrl);
      `DPR_OFF_WIDTH:  rdv = 32'(s_reg.width);
      `DPR_OFF_SHIFT:  rdv = 32'(s_reg.shift);
      `DPR_OFF_STATUS: rdv = {28'h0000000, run_ok, sh_err, cfg_err, s_reg.igo};
      `DPR_OFF_IADDR:  rdv = 32'(s_reg.iaddr);
      `DPR_OFF_ILO:    rdv = s_reg.ilo;
      `DPR_OFF_IHI:    rdv = 32'(s_reg.ihi);
      default:         mapped = 1'b0;
    endcase
    s_next.pready  = acc;
    s_next.pslverr = acc && (!mapped || (pwrite && paddr == `DPR_OFF_STATUS));
    s_next.prdata  = acc && !pwrite ? rdv : '0;
    s_next.igo     = 1'b0;
    // refused transfers never reach the registers
    if (wr_commit) begin
      unique case (paddr)
        `DPR_OFF_CTRL:  s_next.ctrl = pwdata[`DPR_CTRL_W-1:0];
        `DPR_OFF_WIDTH: s_next.width = pwdata[7:0];
        `DPR_OFF_SHIFT: begin
          s_next.shift = pwdata[`DPR_SHIFT_N_W+`DPR_SHIFT_M_W-1:0];
          s_next.sptr  = '0;
        end
        `DPR_OFF_IADDR: s_next.iaddr = pwdata[`DPR_ROW_AW-1:0];
        `DPR_OFF_ILO:   s_next.ilo = pwdata;
        `DPR_OFF_IHI: begin
          s_next.ihi = pwdata[3:0];
          s_next.igo = !s_reg.ctrl[`DPR_CTRL_RUN];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // the array itself keeps its contents through reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg       <= '0;
      s_reg.ctrl  <= `DPR_CTRL_RST;
      s_reg.width <= `DPR_WIDTH_RST;
      s_reg.shift <= `DPR_SHIFT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // array writes
  // ----------------------------------------
  // port B first so port A overrides on an address clash
  always_ff @(posedge sys_clk) begin
    logic [13:0] p;
    if (s_reg.igo)
      mem[s_reg.iaddr] <= {s_reg.ihi, s_reg.ilo};
    if (s_reg.pb.go) begin
      for (int i = 0; i < `DPR_DATA_W; i++) begin
        p = bit_pos(wb, s_reg.pb.addr, i);
        if (p[13] && lane_on(wb, s_reg.ctrl[`DPR_CTRL_BMSK], s_reg.pb.be, i))
          mem[p[12:6]][p[5:0]] <= s_reg.pb.wd[i];
      end
    end
    if (s_reg.pa.go) begin
      for (int i = 0; i < `DPR_DATA_W; i++) begin
        p = bit_pos(wa, s_reg.pa.addr, i);
        if (p[13] && lane_on(wa, s_reg.ctrl[`DPR_CTRL_AMSK], s_reg.pa.be, i))
          mem[p[12:6]][p[5:0]] <= s_reg.pa.wd[i];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign a_rdata = s_reg.pa.rd;
  assign b_rdata = s_reg.pb.rd;

endmodule

`default_nettype wire

/* dpr_consts.svh */
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define DPR_BITS        4608
`define DPR_ROWS        128
`define DPR_ROW_W       36
`define DPR_ROW_AW      7
`define DPR_COL_W       6
`define DPR_ADDR_W      12
`define DPR_DATA_W      36
`define DPR_BE_W        4
`define DPR_NP_BITS     4096
`define DPR_P_LANES     512
`define DPR_LANE_NP     8
`define DPR_LANE_P      9

// ----------------------------------------
// width codes
// ----------------------------------------
`define DPR_W_X16       4'h4
`define DPR_W_X32       4'h5
`define DPR_W_X9        4'h6
`define DPR_W_X18       4'h7
`define DPR_W_X36       4'h8

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DPR_PADDR_W     8
`define DPR_OFF_CTRL    8'h00
`define DPR_OFF_WIDTH   8'h04
`define DPR_OFF_SHIFT   8'h08
`define DPR_OFF_STATUS  8'h0c
`define DPR_OFF_IADDR   8'h10
`define DPR_OFF_ILO     8'h14
`define DPR_OFF_IHI     8'h18

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DPR_CTRL_RUN    0
`define DPR_CTRL_MODE   1
`define DPR_CTRL_ABYP   4
`define DPR_CTRL_BBYP   5
`define DPR_CTRL_AIN    6
`define DPR_CTRL_AOUT   7
`define DPR_CTRL_BIN    8
`define DPR_CTRL_BOUT   9
`define DPR_CTRL_AMSK   10
`define DPR_CTRL_BMSK   11
`define DPR_CTRL_W      12
`define DPR_SHIFT_M_W   12
`define DPR_SHIFT_N_W   6
`define DPR_CTRL_RST    12'h000
`define DPR_WIDTH_RST   8'h00
`define DPR_SHIFT_RST   18'h00000
`define DPR_MODE_NUM    3'h6

`endif

/* dpr_pkg.sv */
`include "dpr_consts.svh"

package dpr_pkg;

  typedef enum logic [2:0] {
    DPR_TDP,
    DPR_SDP,
    DPR_SP,
    DPR_FIFO,
    DPR_ROM,
    DPR_SHIFT
  } dpr_mode_t;

  typedef struct packed {
    logic                       go;
    logic [`DPR_ADDR_W-1:0]     addr;
    logic [`DPR_BE_W-1:0]       be;
    logic [`DPR_DATA_W-1:0]     wd;
    logic [`DPR_DATA_W-1:0]     rq;
    logic [`DPR_DATA_W-1:0]     rd;
  } dpr_port_t;

  typedef struct packed {
    dpr_port_t                  pa;
    dpr_port_t                  pb;
    logic [`DPR_CTRL_W-1:0]     ctrl;
    logic [7:0]                 width;
    logic [`DPR_SHIFT_N_W+`DPR_SHIFT_M_W-1:0] shift;
    logic [`DPR_ROW_AW-1:0]     iaddr;
    logic [31:0]                ilo;
    logic [3:0]                 ihi;
    logic                       igo;
    logic [`DPR_ADDR_W-1:0]     sptr;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } dpr_state_t;

endpackage

/* dpr_block_ram_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.svh"
module dpr_block_ram_monitor
  import dpr_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`DPR_PADDR_W-1:0] paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    a_ce,
  input wire logic                    b_ce,
  input wire logic                    a_clr,
  input wire logic                    b_clr,
  input wire logic [`DPR_DATA_W-1:0]  a_rdata,
  input wire logic [`DPR_DATA_W-1:0]  b_rdata
);
  // ----
  // bus and port checks
  // ----
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  wire logic acc = psel && penable;
  wire logic quiet = !a_ce && !b_ce && !psel;
  a_ready_wait: assert property (acc && !pready |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> acc)
    else $error("pready outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_err_only: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_status: assert property (acc && pready && pwrite && paddr == `DPR_OFF_STATUS |-> pslverr)
    else $error("status write not refused");
  a_err_unmap: assert property (acc && pready && (paddr > `DPR_OFF_IHI || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  a_hold_a: assert property ((quiet && !a_clr) [*4] |-> $stable(a_rdata))
    else $error("a_rdata moved while idle");
  a_hold_b: assert property ((quiet && !b_clr) [*4] |-> $stable(b_rdata))
    else $error("b_rdata moved while idle");
  c_write: cover property (acc && pready && pwrite);
  c_err: cover property (pready && pslverr);
  c_port_b: cover property (b_ce && !a_ce);
endmodule
bind dpr_block_ram dpr_block_ram_monitor MON (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .a_ce(a_ce),
  .b_ce(b_ce), .a_clr(a_clr), .b_clr(b_clr), .a_rdata(a_rdata), .b_rdata(b_rdata));
`default_nettype wire

/* dpr_fabric_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.svh"
module dpr_fabric_model
  import dpr_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic [1:0][`DPR_DATA_W-1:0] rd,
  output logic      [1:0]                  ce,
  output logic      [1:0]                  wren,
  output logic      [1:0]                  clr,
  output logic      [1:0][`DPR_ADDR_W-1:0] addr,
  output logic      [1:0][`DPR_BE_W-1:0]   be,
  output logic      [1:0][`DPR_DATA_W-1:0] wd
);
  // ----
  // one port at a time, never both on one address
  // ----
  initial begin
    ce = '0;
    wren = '0;
    clr = '0;
    addr = '0;
    be = '0;
    wd = '0;
  end
  task automatic op(input int p, input logic w, input logic [11:0] ad, input logic [3:0] b,
                    input logic [35:0] d, output logic [35:0] q);
    @(posedge sys_clk);
    ce[p] <= 1'b1;
    wren[p] <= w;
    addr[p] <= ad;
    be[p] <= b;
    wd[p] <= d;
    @(posedge sys_clk);
    wren[p] <= 1'b0;
    be[p] <= ~b;
    wd[p] <= ~d;
    repeat (5) @(posedge sys_clk);
    q = rd[p];
    ce[p] <= 1'b0;
  endtask
  task automatic clear(input int p, output logic [35:0] q);
    @(posedge sys_clk);
    clr[p] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    q = rd[p];
    clr[p] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dpr_block_ram_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.svh"
module dpr_block_ram_test
  import dpr_pkg::*;
;
  logic                   sys_clk, nrst, psel, penable, pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, rq, lf;
  wire logic [31:0]       prdata;
  wire logic              pready, pslverr;
  wire logic [1:0]        ce, wren, clr;
  wire logic [1:0][11:0]  addr;
  wire logic [1:0][3:0]   be;
  wire logic [1:0][35:0]  wd, rd;
  logic                   re;
  logic [3:0]             b4;
  logic [35:0]            d, t, pq;
  logic [35:0]            mem [8];
  int                     error_cnt, num_checks;
  // ctrl, width, shift, expected error bits
  localparam logic [47:0] CFG [15] = '{48'h001_00_01001_00, 48'h003_00_01001_00,
    48'h005_00_01001_00, 48'h007_00_01001_00, 48'h009_00_01001_00, 48'h00b_00_01001_00,
    48'h001_88_01001_02, 48'h001_55_01001_02, 48'h003_88_01001_00, 48'h003_38_01001_02,
    48'h003_68_01001_00, 48'h00b_88_01080_00, 48'h00b_88_02080_04, 48'h00d_00_01001_02,
    48'h003_99_01001_02};
  dpr_block_ram DUT (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_ce(ce[0]), .a_wren(wren[0]), .a_clr(clr[0]), .a_addr(addr[0]), .a_be(be[0]),
    .a_wdata(wd[0]), .a_rdata(rd[0]), .b_ce(ce[1]), .b_wren(wren[1]), .b_clr(clr[1]),
    .b_addr(addr[1]), .b_be(be[1]), .b_wdata(wd[1]), .b_rdata(rd[1]));
  dpr_fabric_model FAB (
    .sys_clk(sys_clk), .rd(rd), .ce(ce), .wren(wren), .clr(clr), .addr(addr), .be(be), .wd(wd));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] b, int lw);
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < lw; k++)
        if (b[i]) o[i*lw+k] = n[i*lw+k];
    return o;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wdat);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wdat;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[ERR] pready expected 1 seen 0");
      give_verdict();
    end else begin
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] w, input logic [31:0] s);
    apb(1'b1, `DPR_OFF_WIDTH, w);
    apb(1'b1, `DPR_OFF_SHIFT, s);
    apb(1'b1, `DPR_OFF_CTRL, c);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    lf = 32'h00017aa0;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reg reset", 36'h0, {3'h0, re, rq});
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 36'h1, 36'(re));
    apb(1'b1, `DPR_OFF_STATUS, 32'h0);
    chk("status write", 36'h1, 36'(re));
    foreach (CFG[i]) begin
      setup(32'(CFG[i][47:36]), 32'(CFG[i][35:28]), 32'(CFG[i][27:8]));
      apb(1'b0, `DPR_OFF_STATUS, 32'h0);
      chk("cfg status", 36'(CFG[i][7:0]), 36'(rq & 32'h6));
    end
    setup(32'h0, 32'h88, 32'h1001);
    d = 36'({rnd(), rnd()});
    apb(1'b1, `DPR_OFF_IADDR, 32'h5);
    apb(1'b1, `DPR_OFF_ILO, d[31:0]);
    apb(1'b1, `DPR_OFF_IHI, 32'(d[35:32]));
    setup(32'h19, 32'h88, 32'h1001);
    FAB.op(0, 1'b0, 12'h5, 4'hf, 36'h0, pq);
    chk("rom init", d, pq);
    FAB.op(0, 1'b1, 12'h5, 4'hf, ~d, pq);
    chk("rom write", d, pq);
    setup(32'h413, 32'h68, 32'h1001);
    for (int i = 0; i < 8; i++) begin
      mem[i] = 36'({rnd(), rnd()});
      FAB.op(0, 1'b1, 12'(i), 4'hf, mem[i], pq);
      t = 36'({rnd(), rnd()});
      b4 = (i == 0) ? 4'h0 : 4'(rnd());
      FAB.op(0, 1'b1, 12'(i), b4, t, pq);
      mem[i] = merge(mem[i], t, b4, 9);
      chk("x36 masked", mem[i], pq);
      FAB.op(1, 1'b0, 12'(4 * i + i % 4), 4'h0, 36'h0, pq);
      chk("x9 lane", 36'(mem[i][9*(i%4)+:9]), pq);
    end
    setup(32'hc01, 32'h44, 32'h1001);
    for (int i = 0; i < 5; i++) begin
      t = 36'(rnd());
      b4 = (i == 0) ? 4'hf : 4'(i - 1);
      FAB.op(0, 1'b1, 12'h3, b4, t, pq);
      d = merge(d, t, b4, 8) & 36'hffff;
      chk("x16 masked", d, pq);
    end
    setup(32'hcc1, 32'h44, 32'h1001);
    FAB.op(0, 1'b1, 12'h3, 4'hf, ~d, pq);
    chk("a on b_ce", d, pq);
    setup(32'hc01, 32'h44, 32'h1001);
    FAB.op(1, 1'b0, 12'h3, 4'h0, 36'h0, pq);
    chk("b reads a", d, pq);
    t = 36'(rnd());
    FAB.op(1, 1'b1, 12'h9, 4'hf, t, pq);
    FAB.op(0, 1'b0, 12'h9, 4'h0, 36'h0, pq);
    chk("a reads b", t & 36'hffff, pq);
    FAB.clear(0, pq);
    chk("a clear", 36'h0, pq);
    setup(32'hc01, 32'h33, 32'h1001);
    FAB.op(0, 1'b1, 12'h2, 4'h0, t, pq);
    chk("x8 unmasked", t & 36'hff, pq);
    give_verdict();
  end
endmodule
`default_nettype wire
